// ==== hw/alu_pkg.sv ====
// Package with types and constants of the execution datapath
package alu_pkg;
  typedef enum logic [4:0] {
    signed_divide_op, compare_op, twos_complement_op, zero_extend_op,
    sign_extend_op, test_and_set_op, and_op, or_op, xor_op, not_op,
    arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
    rotate_left_plain, rotate_right_plain, rotate_left_with_carry,
    rotate_right_with_carry, bit_set_op, bit_clear_op, bit_invert_op,
    bit_test_op, carry_and_bit, carry_and_inverted_bit, carry_or_bit,
    carry_or_inverted_bit
  } alu_op_e;
  typedef enum logic [1:0] {size_byte, size_word, size_long} alu_size_e;
  typedef enum {st_idle, st_div} alu_state_e;
  // Register offsets
  localparam logic [3:0] ALU_ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ALU_ADDR_RESULT = 4'h4;
  localparam logic [3:0] ALU_ADDR_STATUS = 4'h8;
  // Flag positions in the condition code register
  localparam int ALU_FLAG_C = 0;
  localparam int ALU_FLAG_V = 1;
  localparam int ALU_FLAG_Z = 2;
  localparam int ALU_FLAG_N = 3;
  // Status bit positions
  localparam int ALU_STAT_BUSY = 0;
  localparam int ALU_STAT_DIVZ = 1;
  // Reset values
  localparam logic [3:0] ALU_FLAGS_RESET = 4'h0;
  localparam logic [31:0] ALU_RESULT_RESET = 32'h0;
  // Divider step counts
  localparam logic [5:0] ALU_DIV_STEPS_B = 6'h10;
  localparam logic [5:0] ALU_DIV_STEPS_W = 6'h20;
  // Bit forced by test-and-set
  localparam int ALU_SET_BIT_POS = 7;
endpackage

// ==== hw/alu_core.sv ====
// Execution datapath for divide, compare, logic, shift and bit operations
// Operation
// - Signed divide, 16/8 or 32/16 bits
// - Compare subtracts, updates flags only
// - Negate is zero minus operand
// - Zero-extend low half, upper bits zero
// - Sign-extend low half, copy top bit
// - Test-and-set flags byte, sets bit seven
// - AND, OR, XOR into destination
// - Complement inverts every operand bit
// - Arithmetic shifts one or two, right shift keeps sign
// - Logical shifts insert zeros
// - Plain rotates wrap bits around
// - Rotate through carry as extra bit
// - Bit-set forces selected bit to one
// - Bit-clear forces selected bit to zero
// - Bit-invert toggles selected bit
// - Bit-test loads zero flag inverted
// - Carry ANDed with selected bit
// - Carry ANDed with inverted immediate bit
// - Carry ORed with selected bit
// - Carry ORed with inverted immediate bit
// - Sizes as each operation permits
`timescale 1ns/1ns
`default_nettype none
module alu_core
  import alu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Operation request
  input wire logic op_valid,
  output logic op_ready,
  input wire alu_op_e op_code,
  input wire alu_size_e op_size,
  input wire logic shift_two,
  input wire logic bit_from_reg,
  input wire logic [2:0] bit_imm,
  input wire logic [31:0] dst_val,
  input wire logic [31:0] src_val,
  // Result
  output logic res_valid,
  output logic res_write,
  output logic [31:0] res_data,
  output logic [3:0] condition_code_reg,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  typedef struct packed {
    alu_state_e st;
    logic [3:0] flags;
    logic [31:0] result;
    logic res_valid;
    logic res_write;
    logic [31:0] rdata;
    logic divz;
    logic [5:0] cnt;
    logic [31:0] div_q;
    logic [16:0] div_r;
    logic [15:0] div_d;
    logic div_byte;
    logic q_neg;
    logic r_neg;
    logic [31:0] div_dst;
  } alu_state_s;

  alu_state_s cur, nxt;

  wire logic taken = op_valid && (cur.st == st_idle);
  assign op_ready = (cur.st == st_idle);
  assign res_valid = cur.res_valid;
  assign res_write = cur.res_write;
  assign res_data = cur.result;
  assign condition_code_reg = cur.flags;
  assign reg_rdata = cur.rdata;

  always_comb begin
    int msb;
    logic [31:0] mask;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [32:0] diff;
    logic [3:0] f;
    logic c;
    logic nc;
    logic wr;
    logic [2:0] idx;
    logic bsel;
    logic [15:0] mag_d;
    logic [31:0] mag_n;
    logic [16:0] t;
    logic ge;
    logic [16:0] nr;
    logic [31:0] nq;
    logic [15:0] quo;
    logic [15:0] rem;
    msb = 7;
    mask = 32'h0000_00ff;
    a = 32'h0;
    b = 32'h0;
    r = 32'h0;
    diff = 33'h0;
    f = cur.flags;
    c = cur.flags[ALU_FLAG_C];
    nc = 1'b0;
    wr = 1'b0;
    idx = 3'h0;
    bsel = 1'b0;
    mag_d = 16'h0;
    mag_n = 32'h0;
    t = 17'h0;
    ge = 1'b0;
    nr = 17'h0;
    nq = 32'h0;
    quo = 16'h0;
    rem = 16'h0;
    nxt = cur;
    nxt.res_valid = 1'b0;
    nxt.rdata = 32'h0;
    // Register port
    if (reg_rd) begin
      case (reg_addr)
        ALU_ADDR_FLAGS: nxt.rdata = {28'h0, cur.flags};
        ALU_ADDR_RESULT: nxt.rdata = cur.result;
        ALU_ADDR_STATUS: nxt.rdata = {30'h0, cur.divz, cur.st != st_idle};
        default: nxt.rdata = 32'h0;
      endcase
    end
    if (reg_wr && reg_addr == ALU_ADDR_FLAGS) begin
      nxt.flags = reg_wdata[3:0];
    end
    // Operand width
    case (op_size)
      size_word: begin
        msb = 15;
        mask = 32'h0000_ffff;
      end
      size_long: begin
        msb = 31;
        mask = 32'hffff_ffff;
      end
      default: begin
        msb = 7;
        mask = 32'h0000_00ff;
      end
    endcase
    a = dst_val & mask;
    b = src_val & mask;
    idx = bit_from_reg ? src_val[2:0] : bit_imm;
    bsel = dst_val[idx];
    case (cur.st)
      st_div: begin
        t = {cur.div_r[15:0], cur.div_q[31]};
        ge = t >= {1'b0, cur.div_d};
        nr = ge ? t - {1'b0, cur.div_d} : t;
        nq = {cur.div_q[30:0], ge};
        nxt.div_r = nr;
        nxt.div_q = nq;
        nxt.cnt = cur.cnt - 6'h1;
        if (cur.cnt == 6'h1) begin
          quo = cur.q_neg ? 16'(-nq[15:0]) : nq[15:0];
          rem = cur.r_neg ? 16'(-nr[15:0]) : nr[15:0];
          if (cur.div_byte) begin
            nxt.result = {cur.div_dst[31:16], rem[7:0], quo[7:0]};
            nxt.flags[ALU_FLAG_N] = quo[7];
          end else begin
            nxt.result = {rem, quo};
            nxt.flags[ALU_FLAG_N] = quo[15];
          end
          nxt.flags[ALU_FLAG_Z] = 1'b0;
          nxt.res_valid = 1'b1;
          nxt.res_write = 1'b1;
          nxt.st = st_idle;
        end
      end
      default: begin
        if (taken) begin
          r = a;
          case (op_code)
            signed_divide_op: begin
              nxt.div_dst = dst_val;
              nxt.div_byte = (op_size == size_byte);
              if (op_size == size_byte) begin
                mag_d = src_val[7] ? {8'h0, 8'(-src_val[7:0])} : {8'h0, src_val[7:0]};
                mag_n = {dst_val[15] ? 16'(-dst_val[15:0]) : dst_val[15:0], 16'h0};
                nxt.q_neg = src_val[7] ^ dst_val[15];
                nxt.r_neg = dst_val[15];
                nxt.cnt = ALU_DIV_STEPS_B;
              end else begin
                mag_d = src_val[15] ? 16'(-src_val[15:0]) : src_val[15:0];
                mag_n = dst_val[31] ? 32'(-dst_val) : dst_val;
                nxt.q_neg = src_val[15] ^ dst_val[31];
                nxt.r_neg = dst_val[31];
                nxt.cnt = ALU_DIV_STEPS_W;
              end
              nxt.div_d = mag_d;
              nxt.div_q = mag_n;
              nxt.div_r = 17'h0;
              nxt.divz = (mag_d == 16'h0);
              if (mag_d == 16'h0) begin
                f[ALU_FLAG_Z] = 1'b1;
              end else begin
                nxt.st = st_div;
              end
            end
            compare_op, twos_complement_op: begin
              if (op_code == compare_op) begin
                diff = {1'b0, a} - {1'b0, b};
                f[ALU_FLAG_V] = (a[msb] != b[msb]) && (diff[msb] != a[msb]);
              end else begin
                diff = 33'h0 - {1'b0, a};
                f[ALU_FLAG_V] = a[msb] && diff[msb];
                r = diff[31:0];
                wr = 1'b1;
              end
              f[ALU_FLAG_C] = diff[msb+1];
              f[ALU_FLAG_N] = diff[msb];
              f[ALU_FLAG_Z] = (diff[31:0] & mask) == 32'h0;
            end
            zero_extend_op, sign_extend_op: begin
              if (op_size == size_word) begin
                r = {16'h0, {8{op_code == sign_extend_op && dst_val[7]}},
                     dst_val[7:0]};
              end else begin
                r = {{16{op_code == sign_extend_op && dst_val[15]}}, dst_val[15:0]};
              end
              wr = 1'b1;
            end
            test_and_set_op: begin
              f[ALU_FLAG_N] = dst_val[7];
              f[ALU_FLAG_Z] = dst_val[7:0] == 8'h0;
              f[ALU_FLAG_V] = 1'b0;
              f[ALU_FLAG_C] = 1'b0;
              mask = 32'h0000_00ff;
              r = {24'h0, dst_val[7:0]};
              r[ALU_SET_BIT_POS] = 1'b1;
              wr = 1'b1;
            end
            and_op: begin
              r = a & b;
              wr = 1'b1;
            end
            or_op: begin
              r = a | b;
              wr = 1'b1;
            end
            xor_op: begin
              r = a ^ b;
              wr = 1'b1;
            end
            not_op: begin
              r = ~a & mask;
              wr = 1'b1;
            end
            arith_shift_left, arith_shift_right, logic_shift_left, logic_shift_right,
            rotate_left_plain, rotate_right_plain, rotate_left_with_carry,
            rotate_right_with_carry: begin
              for (int i = 0; i < 2; i++) begin
                if (i == 0 || shift_two) begin
                  case (op_code)
                    arith_shift_left, logic_shift_left: begin
                      c = r[msb];
                      r = (r << 1) & mask;
                    end
                    arith_shift_right: begin
                      c = r[0];
                      r = (r >> 1) | (r & (32'h1 << msb));
                    end
                    logic_shift_right: begin
                      c = r[0];
                      r = r >> 1;
                    end
                    rotate_left_plain: begin
                      c = r[msb];
                      r = ((r << 1) & mask) | {31'h0, c};
                    end
                    rotate_right_plain: begin
                      c = r[0];
                      r = (r >> 1) | ({31'h0, c} << msb);
                    end
                    rotate_left_with_carry: begin
                      nc = r[msb];
                      r = ((r << 1) & mask) | {31'h0, c};
                      c = nc;
                    end
                    default: begin
                      nc = r[0];
                      r = (r >> 1) | ({31'h0, c} << msb);
                      c = nc;
                    end
                  endcase
                end
              end
              f[ALU_FLAG_C] = c;
              wr = 1'b1;
            end
            bit_set_op: begin
              r[idx] = 1'b1;
              wr = 1'b1;
            end
            bit_clear_op: begin
              r[idx] = 1'b0;
              wr = 1'b1;
            end
            bit_invert_op: begin
              r[idx] = ~r[idx];
              wr = 1'b1;
            end
            bit_test_op: f[ALU_FLAG_Z] = ~bsel;
            carry_and_bit: f[ALU_FLAG_C] = c & bsel;
            carry_and_inverted_bit: f[ALU_FLAG_C] = c & ~dst_val[bit_imm];
            carry_or_bit: f[ALU_FLAG_C] = c | bsel;
            carry_or_inverted_bit: f[ALU_FLAG_C] = c | ~dst_val[bit_imm];
            default: wr = 1'b0;
          endcase
          // N, Z and V flags of logic, complement, extend, shift and rotate operations
          if (op_code inside {and_op, or_op, xor_op, not_op, zero_extend_op,
                              sign_extend_op, arith_shift_left, arith_shift_right,
                              logic_shift_left, logic_shift_right, rotate_left_plain,
                              rotate_right_plain, rotate_left_with_carry,
                              rotate_right_with_carry}) begin
            f[ALU_FLAG_N] = r[msb];
            f[ALU_FLAG_Z] = (r & mask) == 32'h0;
            f[ALU_FLAG_V] = 1'b0;
          end
          if (op_code != signed_divide_op || nxt.divz) begin
            nxt.flags = f;
            nxt.res_valid = 1'b1;
            nxt.res_write = wr;
            nxt.result = wr ? ((dst_val & ~mask) | (r & mask)) : dst_val;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '{st: st_idle, flags: ALU_FLAGS_RESET, result: ALU_RESULT_RESET,
               div_r: 17'h0, div_d: 16'h0, cnt: 6'h0, default: '0};
    end else begin
      cur <= nxt;
    end
  end

  compare_nowrite_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == compare_op |-> ##1 res_valid && !res_write && res_data == $past(dst_val))
    else $error("compare wrote a result");
  neg_value_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == twos_complement_op && op_size == size_long
    |-> ##1 res_data == 32'(0 - $past(dst_val)))
    else $error("negate result wrong");
  zext_word_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == zero_extend_op && op_size == size_word
    |-> ##1 res_data[15:0] == {8'h0, $past(dst_val[7:0])})
    else $error("zero extension wrong");
  sext_long_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == sign_extend_op && op_size == size_long
    |-> ##1 res_data[31:16] == {16{$past(dst_val[15])}})
    else $error("sign extension wrong");
  test_set_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == test_and_set_op |-> ##1 res_data[7] && res_write
    && condition_code_reg[ALU_FLAG_Z] == ($past(dst_val[7:0]) == 8'h0))
    else $error("test-and-set wrong");
  not_long_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == not_op && op_size == size_long |-> ##1 res_data == ~$past(dst_val))
    else $error("complement wrong");
  bit_test_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == bit_test_op && !bit_from_reg
    |-> ##1 condition_code_reg[ALU_FLAG_Z] == !$past(dst_val[bit_imm]))
    else $error("bit test flag wrong");
  shift_carry_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == logic_shift_left && op_size == size_long && !shift_two
    |-> ##1 condition_code_reg[ALU_FLAG_C] == $past(dst_val[31]))
    else $error("shift carry wrong");
  div_latency_a: assert property (@(posedge clk) disable iff (!nrst)
    taken && op_code == signed_divide_op && op_size == size_byte && src_val[7:0] != 8'h0
    |-> ##1 (!res_valid && !op_ready) [*8] ##9 res_valid)
    else $error("divide latency wrong");
endmodule
`default_nettype wire

// ==== tb/alu_regfile_model.sv ====
// Register file model on the far side of the datapath
`timescale 1ns/1ns
`default_nettype none
module alu_regfile_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register select, pointer kept to 0, 1, 4 or 5 for test-and-set
  input wire logic [2:0] sel,
  // Result side
  input wire logic res_valid,
  input wire logic res_write,
  input wire logic [31:0] res_data,
  // Operand side
  output logic [31:0] dst_val
);
  logic [31:0] regs [8];
  assign dst_val = regs[sel];
  // Write back only when the datapath asks for it
  always @(posedge clk) begin
    if (nrst && res_valid && res_write) begin
      regs[sel] <= res_data;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the execution datapath
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import alu_pkg::*;
  logic clk, nrst, op_valid, shift_two, bit_from_reg, reg_wr, reg_rd;
  logic op_ready, res_valid, res_write;
  alu_op_e op_code;
  alu_size_e op_size;
  logic [2:0] bit_imm, sel;
  logic [31:0] dst_val, src_val, res_data, reg_wdata, reg_rdata;
  logic [3:0] condition_code_reg, reg_addr;
  int miscompares, check_count, cycles;
  alu_core dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_size(op_size), .shift_two(shift_two),
    .bit_from_reg(bit_from_reg), .bit_imm(bit_imm), .dst_val(dst_val),
    .src_val(src_val), .res_valid(res_valid), .res_write(res_write),
    .res_data(res_data), .condition_code_reg(condition_code_reg),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  alu_regfile_model pm (.clk(clk), .nrst(nrst), .sel(sel), .res_valid(res_valid),
    .res_write(res_write), .res_data(res_data), .dst_val(dst_val));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, x);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // One operation: code, size, by two, index, dst, src, result, write, flag mask, flags, cycles
  task automatic t(input alu_op_e c, input alu_size_e s, input logic two,
    input logic [2:0] im, input logic [31:0] d, input logic [31:0] sv,
    input logic [31:0] e, input logic w, input logic [3:0] m, input logic [3:0] f,
    input int n);
    int k;
    pm.regs[0] = d;
    @(posedge clk);
    op_valid <= 1;
    op_code <= c;
    op_size <= s;
    shift_two <= two;
    bit_imm <= im;
    src_val <= sv;
    @(posedge clk);
    op_valid <= 0;
    k = 1;
    #1;
    if (n > 1) chk({31'h0, op_ready}, 32'h0);
    while (res_valid !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k, n);
    if (w) chk(res_data, e);
    chk({31'h0, res_write}, {31'h0, w});
    chk({28'h0, condition_code_reg & m}, {28'h0, f});
    @(posedge clk);
    #1;
    if (w) chk(pm.regs[0], e);
  endtask
  initial begin
    nrst = 0;
    op_valid = 0;
    op_code = and_op;
    op_size = size_byte;
    shift_two = 0;
    bit_from_reg = 0;
    bit_imm = 3'h0;
    src_val = 32'h0;
    sel = 3'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 0;
    reg_rd = 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    rd(ALU_ADDR_FLAGS, 32'h0);
    rd(4'hc, 32'h0);
    t(and_op, size_long, 0, 0, 32'hf0f0_1234, 32'h0ff0_ff00, 32'h00f0_1200,
      1, 4'hf, 4'h0, 1);
    rd(ALU_ADDR_RESULT, 32'h00f0_1200);
    wr(ALU_ADDR_RESULT, 32'hffff_ffff);
    rd(ALU_ADDR_RESULT, 32'h00f0_1200);
    t(xor_op, size_byte, 0, 0, 32'h1234_5680, 32'h80, 32'h1234_5600, 1, 4'hf, 4'h4, 1);
    t(or_op, size_word, 0, 0, 32'haaaa_0001, 32'h8000, 32'haaaa_8001, 1, 4'hf, 4'h8, 1);
    t(not_op, size_byte, 0, 0, 32'hff, 32'h0, 32'h0, 1, 4'hf, 4'h4, 1);
    t(not_op, size_long, 0, 0, 32'h0f0f_0000, 0, 32'hf0f0_ffff, 1, 4'he, 4'h8, 1);
    t(twos_complement_op, size_word, 0, 0, 32'hffff_0001, 0, 32'hffff_ffff,
      1, 4'hc, 4'h8, 1);
    t(twos_complement_op, size_long, 0, 0, 32'h1, 0, 32'hffff_ffff, 1, 4'hc, 4'h8, 1);
    t(compare_op, size_long, 0, 0, 32'h5, 32'h5, 32'h0, 0, 4'hf, 4'h4, 1);
    t(compare_op, size_byte, 0, 0, 32'h3, 32'h5, 32'h0, 0, 4'hd, 4'h9, 1);
    t(zero_extend_op, size_word, 0, 0, 32'h1234_5680, 0, 32'h1234_0080, 1, 4'he, 4'h0, 1);
    t(sign_extend_op, size_long, 0, 0, 32'h8001, 0, 32'hffff_8001, 1, 4'he, 4'h8, 1);
    t(arith_shift_left, size_byte, 0, 0, 32'h40, 0, 32'h80, 1, 4'hf, 4'h8, 1);
    t(arith_shift_right, size_byte, 1, 0, 32'h81, 0, 32'he0, 1, 4'hf, 4'h8, 1);
    t(logic_shift_left, size_word, 0, 0, 32'h8001, 0, 32'h2, 1, 4'hf, 4'h1, 1);
    t(logic_shift_right, size_long, 0, 0, 32'h1, 0, 32'h0, 1, 4'hf, 4'h5, 1);
    t(rotate_left_plain, size_word, 0, 0, 32'h8000, 0, 32'h1, 1, 4'hf, 4'h1, 1);
    t(rotate_right_plain, size_long, 1, 0, 32'h3, 0, 32'hc000_0000, 1, 4'hf, 4'h9, 1);
    t(logic_shift_left, size_long, 0, 0, 32'h8000_0001, 0, 32'h2, 1, 4'hf, 4'h1, 1);
    wr(ALU_ADDR_FLAGS, 32'h1);
    rd(ALU_ADDR_FLAGS, 32'h1);
    t(rotate_left_with_carry, size_byte, 0, 0, 32'h80, 0, 32'h1, 1, 4'hf, 4'h1, 1);
    t(rotate_right_with_carry, size_long, 0, 0, 0, 0, 32'h8000_0000, 1, 4'hf, 4'h8, 1);
    t(logic_shift_left, size_byte, 0, 0, 32'h80, 0, 32'h0, 1, 4'hf, 4'h5, 1);
    t(carry_and_bit, size_byte, 0, 0, 32'h0, 0, 0, 0, 4'h1, 4'h0, 1);
    t(carry_or_inverted_bit, size_byte, 0, 0, 32'h0, 0, 0, 0, 4'h1, 4'h1, 1);
    bit_from_reg <= 1;
    t(carry_and_inverted_bit, size_byte, 0, 1, 32'h1, 0, 0, 0, 4'h1, 4'h1, 1);
    t(bit_test_op, size_byte, 0, 0, 32'h4, 32'h2, 0, 0, 4'h4, 4'h0, 1);
    t(bit_clear_op, size_byte, 0, 0, 32'hff, 32'h7, 32'h7f, 1, 4'h0, 4'h0, 1);
    bit_from_reg <= 0;
    t(carry_and_bit, size_byte, 0, 0, 32'h0, 0, 0, 0, 4'h1, 4'h0, 1);
    t(carry_or_bit, size_byte, 0, 0, 32'h1, 0, 0, 0, 4'h1, 4'h1, 1);
    t(bit_test_op, size_byte, 0, 2, 32'h4, 0, 0, 0, 4'h4, 4'h0, 1);
    t(bit_set_op, size_byte, 0, 3, 32'h5500_0000, 0, 32'h5500_0008, 1, 0, 0, 1);
    t(bit_invert_op, size_byte, 0, 0, 32'h101, 0, 32'h100, 1, 4'h0, 4'h0, 1);
    t(test_and_set_op, size_byte, 0, 0, 32'hab000000, 0, 32'hab000080, 1, 4'hf, 4'h4, 1);
    t(test_and_set_op, size_byte, 0, 0, 32'h85, 0, 32'h85, 1, 4'hf, 4'h8, 1);
    t(signed_divide_op, size_byte, 0, 0, 32'h1234_0010, 0, 0, 0, 4'h4, 4'h4, 1);
    rd(ALU_ADDR_STATUS, 32'h2);
    t(signed_divide_op, size_byte, 0, 0, 32'hfff9, 32'h2, 32'hfffd, 1, 4'hc, 4'h8, 17);
    t(signed_divide_op, size_word, 0, 0, 32'h64, 32'hfff9, 32'h2fff2, 1, 4'hc, 4'h8, 33);
    rd(ALU_ADDR_STATUS, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
